// *** vpmpm_defs.svh ***
// Offsets, field positions, reset values and aperture bounds of the plane mask and page map block
// Included by both ends and by the testbench
`ifndef VPMPM_DEFS_SVH
`define VPMPM_DEFS_SVH
// I/O ports
`define VPMPM_PORT_GFX_INDEX 16'h03CE
`define VPMPM_PORT_GFX_DATA 16'h03CF
`define VPMPM_PORT_MISC_OUT_WR 16'h03C2
`define VPMPM_PORT_MISC_OUT_RD 16'h03CC
// Graphics controller indexes
`define VPMPM_IDX_MISC_GFX 8'h06
`define VPMPM_IDX_BIT_MASK 8'h08
`define VPMPM_IDX_PAGING 8'h10
`define VPMPM_IDX_PAGE_SEL 8'h11
// Reset values
`define VPMPM_PAGING_RST 8'h00
`define VPMPM_PAGE_SEL_RST 8'h00
`define VPMPM_BIT_MASK_RST 8'hFF
`define VPMPM_MISC_GFX_RST 8'h00
`define VPMPM_MISC_OUT_RST 8'h00
// Field positions and codes
`define VPMPM_PG_EN_BIT 0
`define VPMPM_PG_TGT_LSB 1
`define VPMPM_MAP_MODE_LSB 2
`define VPMPM_APER_EN_BIT 1
`define VPMPM_TGT_VGA_MEM 2'h0
`define VPMPM_MAP_A_ONLY 2'h1
// Aperture bounds
`define VPMPM_APER_A_LO 20'hA_0000
`define VPMPM_APER_A_HI 20'hA_FFFF
`define VPMPM_APER_B_LO 20'hB_0000
`define VPMPM_APER_B_MID 20'hB_7FFF
`define VPMPM_APER_B8_LO 20'hB_8000
`define VPMPM_APER_B_HI 20'hB_FFFF
// Host APB register offsets
`define VPMPM_APB_CMD 12'h000
`define VPMPM_APB_ADDR 12'h004
`define VPMPM_APB_WDATA 12'h008
`define VPMPM_APB_STATUS 12'h00C
`define VPMPM_APB_RDATA 12'h010
`define VPMPM_APB_CFG 12'h014
`endif

// *** vpmpm_dev.sv ***
// Graphics device end: graphics index/data registers, plane write mask and aperture page map
// Assumes a frame-buffer memory on pclk that returns read data one cycle after mem_en
`include "vpmpm_defs.svh"
`timescale 1ns/1ps
// Functional notes
// - Mask bit 0 writes latch bit back
// - Mask bit 1 passes write path data
// - One mask shared by all four planes
// - Mask applied after the write path
// - Host does read, set mask, then write
// - Page extension bits never reach address
// - Target 00 is VGA memory; others reserved
// - VGA memory at stolen base, 128 pages
// - Paged accesses skip plane address swizzle
// - Paged address is page select plus A15..2
// - Host sets map mode 01 before paging
// - Aperture needs memory and aperture enable
// - Host reaches paging control by I/O only
// - Paging control resets to zero
// - Page select gives address bits 22..16
// - Map mode 01 limits aperture to A segment
module vpmpm_dev #(
	parameter int MEM_AW = 21
) (
	input wire logic pclk,
	input wire logic presetn,
	vpmpm_if.dev bus,
	input wire logic [3:0] plane_enable,
	input wire logic [MEM_AW-1:0] stolen_base,
	input wire logic [31:0] mem_rdata,
	output logic mem_en,
	output logic mem_we,
	output logic [3:0] mem_be,
	output logic [MEM_AW-1:0] mem_addr,
	output logic [31:0] mem_wdata
);
	vpmpm_pkg::vpmpm_dev_s s;
	vpmpm_pkg::vpmpm_dev_s n;
	logic [19:0] addr;
	logic [1:0] map_mode;
	logic aper_on;
	logic hit;
	logic [16:0] off;
	logic paged;
	logic [1:0] target;
	logic [20:0] word_addr;
	logic [3:0] be;
	logic [7:0] reg_rd;
	logic [31:0] merged;

	if (MEM_AW != 21)
	begin : g_bad_aw
		$error("MEM_AW must be 21");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Aperture decode and address generation
	assign addr = bus.req_addr;
	assign map_mode = s.misc_gfx[`VPMPM_MAP_MODE_LSB +: 2];
	assign aper_on = bus.pci_mem_en && s.misc_out[`VPMPM_APER_EN_BIT];
	assign paged = s.paging[`VPMPM_PG_EN_BIT];
	assign target = s.paging[`VPMPM_PG_TGT_LSB +: 2];

	always_comb
	begin
		hit = 1'b0;
		off = 17'h0_0000;
		if (map_mode == 2'h0)
		begin
			hit = (addr >= `VPMPM_APER_A_LO) && (addr <= `VPMPM_APER_B_HI);
			off = 17'(addr - `VPMPM_APER_A_LO);
		end
		else if (map_mode == `VPMPM_MAP_A_ONLY)
		begin
			hit = (addr >= `VPMPM_APER_A_LO) && (addr <= `VPMPM_APER_A_HI);
			off = {1'b0, addr[15:0]};
		end
		else if (map_mode == 2'h2)
		begin
			hit = (addr >= `VPMPM_APER_B_LO) && (addr <= `VPMPM_APER_B_MID);
			off = {2'h0, addr[14:0]};
		end
		else
		begin
			hit = (addr >= `VPMPM_APER_B8_LO) && (addr <= `VPMPM_APER_B_HI);
			off = {2'h0, addr[14:0]};
		end
		hit = hit && aper_on;
	end

	always_comb
	begin
		if (paged)
		begin
			// Linear map, one byte lane per access
			word_addr = {s.page_sel[6:0], addr[15:2]};
			be = 4'h1 << addr[1:0];
		end
		else
		begin
			// Planar map within the first four pages
			word_addr = {5'h00, off[15:0]};
			be = plane_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Plane write mask merge
	for (genvar b = 0; b < 32; b++)
	begin : g_merge
		assign merged[b] = s.bit_mask[b % 8] ? bus.req_wdata[b % 8] : s.latch[b];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb
	begin
		reg_rd = 8'h00;
		if (s.gfx_index == `VPMPM_IDX_MISC_GFX)
			reg_rd = {4'h0, s.misc_gfx[3:0]};
		else if (s.gfx_index == `VPMPM_IDX_BIT_MASK)
			reg_rd = s.bit_mask;
		else if (s.gfx_index == `VPMPM_IDX_PAGING)
			reg_rd = s.paging;
		else if (s.gfx_index == `VPMPM_IDX_PAGE_SEL)
			reg_rd = s.page_sel;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request handling
	always_comb
	begin
		n = s;
		n.ack = 1'b0;
		n.mem_en = 1'b0;
		n.mem_we = 1'b0;
		case (s.st)
			vpmpm_pkg::VPMPM_DEV_IDLE:
				if (bus.req_valid && !s.ack)
				begin
					n.ack = 1'b1;
					n.rdata = 8'hFF;
					if (bus.req_io)
					begin
						if (addr[15:0] == `VPMPM_PORT_GFX_INDEX)
						begin
							n.rdata = s.gfx_index;
							if (bus.req_write)
								n.gfx_index = bus.req_wdata;
						end
						else if (addr[15:0] == `VPMPM_PORT_GFX_DATA)
						begin
							n.rdata = reg_rd;
							if (bus.req_write)
							begin
								if (s.gfx_index == `VPMPM_IDX_MISC_GFX)
									n.misc_gfx = {4'h0, bus.req_wdata[3:0]};
								else if (s.gfx_index == `VPMPM_IDX_BIT_MASK)
									n.bit_mask = bus.req_wdata;
								else if (s.gfx_index == `VPMPM_IDX_PAGING)
									n.paging = {bus.req_wdata[7:4], 1'b0, bus.req_wdata[2:0]};
								else if (s.gfx_index == `VPMPM_IDX_PAGE_SEL)
									n.page_sel = {1'b0, bus.req_wdata[6:0]};
							end
						end
						else if (addr[15:0] == `VPMPM_PORT_MISC_OUT_WR && bus.req_write)
							n.misc_out = bus.req_wdata;
						else if (addr[15:0] == `VPMPM_PORT_MISC_OUT_RD && !bus.req_write)
							n.rdata = s.misc_out;
					end
					else if (hit && !(paged && target != `VPMPM_TGT_VGA_MEM))
					begin
						n.mem_en = 1'b1;
						n.mem_we = bus.req_write;
						n.mem_be = be;
						n.mem_addr = MEM_AW'(stolen_base + word_addr);
						n.mem_wdata = merged;
						n.rd_lane = paged ? addr[1:0] : 2'h0;
						if (!bus.req_write)
						begin
							n.ack = 1'b0;
							n.st = vpmpm_pkg::VPMPM_DEV_RD_WAIT;
						end
					end
				end
			vpmpm_pkg::VPMPM_DEV_RD_WAIT:
				n.st = vpmpm_pkg::VPMPM_DEV_RD_DATA;
			vpmpm_pkg::VPMPM_DEV_RD_DATA:
			begin
				n.latch = mem_rdata;
				n.rdata = mem_rdata[{s.rd_lane, 3'h0} +: 8];
				n.ack = 1'b1;
				n.st = vpmpm_pkg::VPMPM_DEV_IDLE;
			end
			default:
				n.st = vpmpm_pkg::VPMPM_DEV_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.st <= vpmpm_pkg::VPMPM_DEV_IDLE;
			s.misc_gfx <= `VPMPM_MISC_GFX_RST;
			s.bit_mask <= `VPMPM_BIT_MASK_RST;
			s.paging <= `VPMPM_PAGING_RST;
			s.page_sel <= `VPMPM_PAGE_SEL_RST;
			s.misc_out <= `VPMPM_MISC_OUT_RST;
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.ack = s.ack;
	assign bus.rdata = s.rdata;
	assign mem_en = s.mem_en;
	assign mem_we = s.mem_we;
	assign mem_be = s.mem_be;
	assign mem_addr = s.mem_addr;
	assign mem_wdata = s.mem_wdata;
endmodule

// *** vpmpm_host.sv ***
// Host CPU end: APB command registers turned into I/O and frame-buffer cycles
// Assumes a device end on the same pclk that answers each request with a one-cycle ack
`include "vpmpm_defs.svh"
`timescale 1ns/1ps
module vpmpm_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	vpmpm_if.host bus
);
	vpmpm_pkg::vpmpm_host_s s;
	vpmpm_pkg::vpmpm_host_s n;
	vpmpm_pkg::vpmpm_micro_s mu;
	logic apb_wr;
	logic [1:0] last_step;

	////////////////////////////////////////////////////////////////////////////////
	// Micro steps of each command
	always_comb
	begin
		mu = '0;
		last_step = 2'h0;
		case (s.op)
			vpmpm_pkg::VPMPM_OP_IOW:
			begin
				last_step = 2'h3;
				mu.io = 1'b1;
				mu.write = 1'b1;
				case (s.step)
					2'h0:
					begin
						mu.addr = {4'h0, `VPMPM_PORT_GFX_INDEX};
						mu.data = `VPMPM_IDX_MISC_GFX;
					end
					2'h1:
					begin
						mu.addr = {4'h0, `VPMPM_PORT_GFX_DATA};
						mu.data = {s.shadow_gfx[7:4], `VPMPM_MAP_A_ONLY, s.shadow_gfx[1:0]};
					end
					2'h2:
					begin
						mu.addr = {4'h0, `VPMPM_PORT_GFX_INDEX};
						mu.data = s.addr[7:0];
					end
					default:
					begin
						mu.addr = {4'h0, `VPMPM_PORT_GFX_DATA};
						mu.data = s.wdata[7:0];
						if (s.addr[7:0] == `VPMPM_IDX_PAGING)
							mu.data[2:1] = `VPMPM_TGT_VGA_MEM;
					end
				endcase
			end
			vpmpm_pkg::VPMPM_OP_IOR:
			begin
				last_step = 2'h1;
				mu.io = 1'b1;
				mu.write = (s.step == 2'h0);
				mu.addr = {4'h0, (s.step == 2'h0) ? `VPMPM_PORT_GFX_INDEX : `VPMPM_PORT_GFX_DATA};
				mu.data = s.addr[7:0];
			end
			vpmpm_pkg::VPMPM_OP_PORTW, vpmpm_pkg::VPMPM_OP_PORTR:
			begin
				mu.io = 1'b1;
				mu.write = (s.op == vpmpm_pkg::VPMPM_OP_PORTW);
				mu.addr = {4'h0, s.addr[15:0]};
				mu.data = s.wdata[7:0];
			end
			vpmpm_pkg::VPMPM_OP_MEMW, vpmpm_pkg::VPMPM_OP_MEMR:
			begin
				mu.write = (s.op == vpmpm_pkg::VPMPM_OP_MEMW);
				mu.addr = s.addr;
				mu.data = s.wdata[7:0];
			end
			default:
			begin
				// Read byte, set mask, write same byte
				last_step = 2'h3;
				mu.io = (s.step == 2'h1) || (s.step == 2'h2);
				mu.write = (s.step != 2'h0);
				mu.addr = s.addr;
				mu.data = s.wdata[7:0];
				if (s.step == 2'h1)
				begin
					mu.addr = {4'h0, `VPMPM_PORT_GFX_INDEX};
					mu.data = `VPMPM_IDX_BIT_MASK;
				end
				else if (s.step == 2'h2)
				begin
					mu.addr = {4'h0, `VPMPM_PORT_GFX_DATA};
					mu.data = s.wdata[15:8];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave and command sequencer
	assign apb_wr = psel && penable && s.pready && pwrite;

	always_comb
	begin
		n = s;
		n.pready = psel && penable && !s.pready;
		if (psel && penable && !s.pready)
		begin
			n.prdata = 32'h0000_0000;
			if (paddr == `VPMPM_APB_CMD)
				n.prdata = {29'h0000_0000, s.op};
			else if (paddr == `VPMPM_APB_ADDR)
				n.prdata = {12'h000, s.addr};
			else if (paddr == `VPMPM_APB_WDATA)
				n.prdata = {16'h0000, s.wdata};
			else if (paddr == `VPMPM_APB_STATUS)
				n.prdata = {31'h0000_0000, s.busy};
			else if (paddr == `VPMPM_APB_RDATA)
				n.prdata = {24'h00_0000, s.rdata};
			else if (paddr == `VPMPM_APB_CFG)
				n.prdata = {31'h0000_0000, s.pci_en};
		end
		if (apb_wr && !s.busy)
		begin
			if (paddr == `VPMPM_APB_ADDR)
				n.addr = pwdata[19:0];
			else if (paddr == `VPMPM_APB_WDATA)
				n.wdata = pwdata[15:0];
			else if (paddr == `VPMPM_APB_CFG)
				n.pci_en = pwdata[0];
			else if (paddr == `VPMPM_APB_CMD && pwdata[2:0] <= 3'h6)
			begin
				n.op = vpmpm_pkg::vpmpm_op_e'(pwdata[2:0]);
				n.busy = 1'b1;
				n.st = vpmpm_pkg::VPMPM_HOST_ISSUE;
				n.step = 2'h0;
				if (pwdata[2:0] == 3'h0 && !(s.addr[7:0] == `VPMPM_IDX_PAGING && s.wdata[0]))
					n.step = 2'h2;
				if (pwdata[2:0] == 3'h0 && s.addr[7:0] == `VPMPM_IDX_MISC_GFX)
					n.shadow_gfx = s.wdata[7:0];
			end
		end
		case (s.st)
			vpmpm_pkg::VPMPM_HOST_IDLE:
				n.busy = n.busy;
			vpmpm_pkg::VPMPM_HOST_ISSUE:
			begin
				n.req_valid = 1'b1;
				n.req_io = mu.io;
				n.req_write = mu.write;
				n.req_addr = mu.addr;
				n.req_wdata = mu.data;
				n.st = vpmpm_pkg::VPMPM_HOST_WAIT;
			end
			vpmpm_pkg::VPMPM_HOST_WAIT:
				if (bus.ack)
				begin
					n.req_valid = 1'b0;
					if (!s.req_write)
						n.rdata = bus.rdata;
					if (s.step == last_step)
					begin
						n.busy = 1'b0;
						n.st = vpmpm_pkg::VPMPM_HOST_IDLE;
					end
					else
					begin
						n.step = s.step + 2'h1;
						n.st = vpmpm_pkg::VPMPM_HOST_ISSUE;
					end
				end
			default:
				n.st = vpmpm_pkg::VPMPM_HOST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= n;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = 1'b0;
	assign bus.req_valid = s.req_valid;
	assign bus.req_io = s.req_io;
	assign bus.req_write = s.req_write;
	assign bus.req_addr = s.req_addr;
	assign bus.req_wdata = s.req_wdata;
	assign bus.pci_mem_en = s.pci_en;
endmodule

// *** vpmpm_if.sv ***
// Link between the host CPU end and the graphics device end
// Both ends run on the same pclk
`timescale 1ns/1ps
interface vpmpm_if;
	logic req_valid;
	logic req_io;
	logic req_write;
	logic [19:0] req_addr;
	logic [7:0] req_wdata;
	logic pci_mem_en;
	logic ack;
	logic [7:0] rdata;
	modport host (output req_valid, output req_io, output req_write, output req_addr,
		output req_wdata, output pci_mem_en, input ack, input rdata);
	modport dev (input req_valid, input req_io, input req_write, input req_addr,
		input req_wdata, input pci_mem_en, output ack, output rdata);
endinterface

// *** vpmpm_pkg.sv ***
// Types shared by both ends of the plane mask and page map block
// Assumes vpmpm_defs.svh is on the include path
package vpmpm_pkg;
	typedef enum logic [1:0] {VPMPM_DEV_IDLE, VPMPM_DEV_RD_WAIT, VPMPM_DEV_RD_DATA} vpmpm_dev_state_e;
	typedef enum logic [1:0] {VPMPM_HOST_IDLE, VPMPM_HOST_ISSUE, VPMPM_HOST_WAIT} vpmpm_host_state_e;
	typedef enum logic [2:0] {
		VPMPM_OP_IOW = 3'h0,
		VPMPM_OP_IOR = 3'h1,
		VPMPM_OP_PORTW = 3'h2,
		VPMPM_OP_PORTR = 3'h3,
		VPMPM_OP_MEMW = 3'h4,
		VPMPM_OP_MEMR = 3'h5,
		VPMPM_OP_RMW = 3'h6
	} vpmpm_op_e;
	typedef struct packed {
		logic io;
		logic write;
		logic [19:0] addr;
		logic [7:0] data;
	} vpmpm_micro_s;
	typedef struct packed {
		vpmpm_dev_state_e st;
		logic [7:0] gfx_index;
		logic [7:0] misc_gfx;
		logic [7:0] bit_mask;
		logic [7:0] paging;
		logic [7:0] page_sel;
		logic [7:0] misc_out;
		logic [31:0] latch;
		logic ack;
		logic [7:0] rdata;
		logic mem_en;
		logic mem_we;
		logic [3:0] mem_be;
		logic [20:0] mem_addr;
		logic [31:0] mem_wdata;
		logic [1:0] rd_lane;
	} vpmpm_dev_s;
	typedef struct packed {
		vpmpm_host_state_e st;
		vpmpm_op_e op;
		logic [1:0] step;
		logic busy;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [7:0] rdata;
		logic [7:0] shadow_gfx;
		logic pci_en;
		logic req_valid;
		logic req_io;
		logic req_write;
		logic [19:0] req_addr;
		logic [7:0] req_wdata;
		logic pready;
		logic [31:0] prdata;
	} vpmpm_host_s;
endpackage

// *** vpmpm_props.sv ***
// Link checker for the plane mask and page map block
// Sees the link signals and the memory strobes; reset is async active low
`timescale 1ns/1ps
module vpmpm_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic req_io,
	input wire logic req_write,
	input wire logic [19:0] req_addr,
	input wire logic pci_mem_en,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic mem_en,
	input wire logic mem_we
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	// Link handshake
	a_ack_single_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_req_held_stable: assert property (req_valid && !ack |=> req_valid && $stable(req_addr)
		&& $stable(req_io) && $stable(req_write))
		else $error("request changed before ack");
	a_ack_in_time: assert property ($rose(req_valid) |-> ##[1:3] ack)
		else $error("no ack within three cycles");
	a_ack_then_idle: assert property (ack |=> !req_valid)
		else $error("request not released after ack");
	a_ack_needs_req: assert property (ack |-> req_valid)
		else $error("ack without request");
	////////////////////////////////////////////////////////////////////////////////
	// Memory cycles
	a_mem_enabled_only: assert property (mem_en |-> pci_mem_en && !req_io
		&& req_addr[19:17] == 3'h5)
		else $error("memory cycle outside enabled aperture");
	a_refused_reads_ff: assert property (req_valid && !req_io && !req_write && !pci_mem_en
		&& !ack |=> ack && rdata == 8'hFF)
		else $error("disabled read not refused with FF");
	a_write_acked_now: assert property (mem_en && mem_we |-> ack)
		else $error("memory write not acked with strobe");
	a_read_two_later: assert property (mem_en && !mem_we |-> !ack ##2 ack)
		else $error("memory read ack latency wrong");
	a_io_no_memory: assert property (req_valid && req_io |-> !mem_en)
		else $error("memory cycle during I/O cycle");
	c_mem_write: cover property (mem_en && mem_we);
	c_mem_read: cover property (mem_en && !mem_we);
	c_refused: cover property (ack && rdata == 8'hFF);
endmodule

// *** vpmpm_tb.sv ***
// Testbench for the plane mask and page map block: host and device joined by the link
// Assumes the host APB map and ops of the package; memory is a one-cycle sync RAM model
`include "vpmpm_defs.svh"
`timescale 1ns/1ps
module vpmpm_tb;
	localparam logic [20:0] BASE = 21'h00_1000;
	logic pclk, presetn, psel, penable, pwrite, pready, mem_en, mem_we;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_rdata, mem_wdata, rd;
	logic [3:0] plane_enable, mem_be;
	logic [20:0] mem_addr;
	logic [31:0] mem [int];
	logic [7:0] lane;
	int failures, total_checks;
	logic hung;
	vpmpm_if i_vpmpm_if ();
	vpmpm_host i_vpmpm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(), .bus(i_vpmpm_if.host));
	vpmpm_dev #(.MEM_AW(21)) i_vpmpm_dev (.pclk(pclk), .presetn(presetn), .bus(i_vpmpm_if.dev),
		.plane_enable(plane_enable), .stolen_base(BASE), .mem_rdata(mem_rdata), .mem_en(mem_en),
		.mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	vpmpm_props i_vpmpm_props (.pclk(pclk), .presetn(presetn), .req_valid(i_vpmpm_if.req_valid),
		.req_io(i_vpmpm_if.req_io), .req_write(i_vpmpm_if.req_write),
		.req_addr(i_vpmpm_if.req_addr), .pci_mem_en(i_vpmpm_if.pci_mem_en),
		.ack(i_vpmpm_if.ack), .rdata(i_vpmpm_if.rdata), .mem_en(mem_en), .mem_we(mem_we));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and memory model
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (mem_en && mem_we)
			for (int p = 0; p < 4; p++)
				if (mem_be[p])
					mem[int'(mem_addr)][8*p +: 8] = mem_wdata[8*p +: 8];
		mem_rdata <= (mem_en && !mem_we) ? mem[int'(mem_addr)] : ~mem_rdata;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		if (hung)
			return;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			chk("pready timeout", 32'h0000_0001, 32'h0000_0000);
			hung = 1'b1;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input vpmpm_pkg::vpmpm_op_e op, input logic [19:0] a, input logic [15:0] d);
		int n;
		apb(1'b1, `VPMPM_APB_ADDR, {12'h000, a});
		apb(1'b1, `VPMPM_APB_WDATA, {16'h0000, d});
		apb(1'b1, `VPMPM_APB_CMD, 32'(op));
		n = 0;
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0 && n < 40 && !hung)
		begin
			apb(1'b0, `VPMPM_APB_STATUS, 32'h0000_0000);
			n++;
		end
		if (n >= 40)
		begin
			chk("busy timeout", 32'h0000_0000, 32'h0000_0001);
			hung = 1'b1;
		end
		apb(1'b0, `VPMPM_APB_RDATA, 32'h0000_0000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_values();
		run(vpmpm_pkg::VPMPM_OP_IOR, 20'h0_0010, 16'h0000);
		chk("paging_control reset", 32'h0000_0000, rd);
	endtask
	task automatic t_rmw_masks();
		logic [7:0] masks [3] = '{8'h00, 8'h5A, 8'hFF};
		apb(1'b1, `VPMPM_APB_CFG, 32'h0000_0001);
		run(vpmpm_pkg::VPMPM_OP_PORTW, 20'h0_03C2, 16'h0002);
		foreach (masks[i])
		begin
			run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hA_0000, 16'h00AA);
			run(vpmpm_pkg::VPMPM_OP_RMW, 20'hA_0000, {masks[i], 8'h55});
			lane = (8'h55 & masks[i]) | (8'hAA & ~masks[i]);
			chk("rmw word", {4{lane}}, mem[int'(BASE)]);
		end
		run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hA_0004, 16'h0000);
		@(posedge pclk);
		plane_enable <= 4'h5;
		run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hA_0004, 16'h003C);
		chk("plane subset word", 32'h003C_003C, mem[int'(BASE + 21'h00_0004)]);
		@(posedge pclk);
		plane_enable <= 4'hF;
	endtask
	task automatic t_paging();
		run(vpmpm_pkg::VPMPM_OP_IOW, 20'h0_0011, 16'h0005);
		run(vpmpm_pkg::VPMPM_OP_IOW, 20'h0_0010, 16'h00F1);
		run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hA_1236, 16'h0077);
		chk("paged byte", 32'h0000_0077, {24'h00_0000, mem[int'(BASE + 21'h01_448D)][23:16]});
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hA_1236, 16'h0000);
		chk("paged read", 32'h0000_0077, rd);
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hB_0000, 16'h0000);
		chk("b segment refused", 32'h0000_00FF, rd);
		run(vpmpm_pkg::VPMPM_OP_PORTW, 20'h0_03CE, 16'h0010);
		run(vpmpm_pkg::VPMPM_OP_PORTW, 20'h0_03CF, 16'h0003);
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hA_1236, 16'h0000);
		chk("reserved target refused", 32'h0000_00FF, rd);
		run(vpmpm_pkg::VPMPM_OP_IOW, 20'h0_0010, 16'h0000);
		run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hA_0008, 16'h0011);
		chk("unpaged word", 32'h1111_1111, mem[int'(BASE + 21'h00_0008)]);
	endtask
	task automatic t_enables();
		logic [1:0] cases [2] = '{2'h1, 2'h2};
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hA_0008, 16'h0000);
		chk("enabled read", 32'h0000_0011, rd);
		foreach (cases[i])
		begin
			apb(1'b1, `VPMPM_APB_CFG, {31'h0000_0000, cases[i][1]});
			run(vpmpm_pkg::VPMPM_OP_PORTW, 20'h0_03C2, {14'h0000, cases[i][0], 1'b0});
			run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hA_0008, 16'h0000);
			chk("disabled read", 32'h0000_00FF, rd);
		end
	endtask
	task automatic t_map_modes();
		apb(1'b1, `VPMPM_APB_CFG, 32'h0000_0001);
		run(vpmpm_pkg::VPMPM_OP_PORTW, 20'h0_03C2, 16'h0002);
		run(vpmpm_pkg::VPMPM_OP_IOW, 20'h0_0006, 16'h0008);
		run(vpmpm_pkg::VPMPM_OP_MEMW, 20'hB_0010, 16'h0022);
		chk("b low word", 32'h2222_2222, mem[int'(BASE + 21'h00_0010)]);
		run(vpmpm_pkg::VPMPM_OP_IOW, 20'h0_0006, 16'h000C);
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hB_8010, 16'h0000);
		chk("b high read", 32'h0000_0022, rd);
		run(vpmpm_pkg::VPMPM_OP_MEMR, 20'hA_0008, 16'h0000);
		chk("a outside mode", 32'h0000_00FF, rd);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		plane_enable = 4'hF;
		mem_rdata = 32'h0000_0000;
		failures = 0;
		total_checks = 0;
		hung = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_rmw_masks();
		t_paging();
		t_enables();
		t_map_modes();
		print_verdict();
	end
endmodule
